// file: mise_exec.sv
// instruction subset execution unit with apb register access
//
// Summary of operation
// - move-from-special-page copies special register 0..21 into accumulator, flags kept.
// - register subtract computes file minus accumulator, updates zero, digit carry, carry.
// - destination bit 0 writes accumulator, 1 writes back the source file register.
// - immediate subtract computes immediate minus accumulator into accumulator, updating flags.
// - halt clears watchdog counter and its prescaler to zero in one cycle.
// - halt sets timeout flag, clears powerdown flag, then execution stops.
// - nibble swap exchanges high and low nibbles, leaving all flags unchanged.
// - timer-mode load copies accumulator into timer0 mode register, flags kept.
// - store-to-special-page loads accumulator into special register 0..21, flags kept.
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module mise_exec (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [7:0] timer0_mode_register,
    output mise_pkg::mise_state_e core_state
);
    import mise_pkg::*;

    logic [7:0] accumulator;
    logic carry_flag;
    logic digit_carry_flag;
    logic zero_flag;
    logic timeout_flag_n;
    logic powerdown_flag_n;
    logic [7:0] watchdog_count;
    logic [7:0] watchdog_prescaler;
    logic [7:0] file_reg [0:127];
    logic [7:0] spec_reg [0:21];

    logic xfer_done;
    logic wr_done;
    logic exec_fire;
    mise_op_e op;
    logic [6:0] fidx;
    logic [4:0] sidx;
    logic dest_file;
    logic [7:0] imm;
    logic [7:0] file_rd;
    logic [7:0] spec_rd;
    logic [7:0] alu_minuend;
    logic [7:0] alu_diff;
    logic alu_c;
    logic alu_digit;
    logic alu_z;
    logic [7:0] alu_swap;

    function automatic logic in_file(input logic [11:0] a);
        in_file = (a[11:9] == FILE_PAGE) && (a[1:0] == 2'h0);
    endfunction : in_file

    function automatic logic in_spec(input logic [11:0] a);
        in_spec = (a[11:7] == SPEC_PAGE) && (a[6:2] <= SPEC_LAST) && (a[1:0] == 2'h0);
    endfunction : in_spec

    function automatic logic op_legal(input logic [31:0] w);
        logic [3:0] code;
        code = w[EXEC_OP_LSB +: EXEC_OP_W];
        op_legal = (code <= OP_LOAD_TMODE)
            && !(((code == OP_MOVE_SP) || (code == OP_LOAD_SP))
                 && (w[EXEC_OPND_LSB +: 5] > SPEC_LAST));
    endfunction : op_legal

    // unmapped, read-only written, bad instruction or instruction while halted
    function automatic logic access_err(input logic [11:0] a, input logic wr,
                                        input logic [31:0] w);
        logic mapped;
        mapped = (a == OFF_EXEC) || (a == OFF_ACCUM) || (a == OFF_STATUS)
            || (a == OFF_TMODE) || (a == OFF_WDT) || in_file(a) || in_spec(a);
        access_err = !mapped || (wr && (a == OFF_WDT))
            || (wr && (a == OFF_EXEC) && (!op_legal(w) || (core_state == ST_HALTED)));
    endfunction : access_err

    function automatic logic [31:0] reg_read(input logic [11:0] a);
        reg_read = 32'h0000_0000;
        if (a == OFF_ACCUM) begin
            reg_read[7:0] = accumulator;
        end else if (a == OFF_STATUS) begin
            reg_read[STAT_C] = carry_flag;
            reg_read[STAT_DIGIT] = digit_carry_flag;
            reg_read[STAT_Z] = zero_flag;
            reg_read[STAT_PWRDN] = powerdown_flag_n;
            reg_read[STAT_TMOUT] = timeout_flag_n;
            reg_read[STAT_HALT] = (core_state == ST_HALTED);
        end else if (a == OFF_TMODE) begin
            reg_read[7:0] = timer0_mode_register;
        end else if (a == OFF_WDT) begin
            reg_read[WDT_CNT_LSB +: 8] = watchdog_count;
            reg_read[WDT_PRE_LSB +: 8] = watchdog_prescaler;
        end else if (in_file(a)) begin
            reg_read[7:0] = file_reg[a[8:2]];
        end else if (in_spec(a)) begin
            reg_read[7:0] = spec_reg[a[6:2]];
        end
    endfunction : reg_read

    assign xfer_done = psel && penable && pready;
    assign wr_done = xfer_done && pwrite && !pslverr;
    assign exec_fire = wr_done && (paddr == OFF_EXEC) && (core_state == ST_RUN);
    assign op = mise_op_e'(pwdata[EXEC_OP_LSB +: EXEC_OP_W]);
    assign fidx = pwdata[EXEC_OPND_LSB +: 7];
    assign sidx = pwdata[EXEC_OPND_LSB +: 5];
    assign dest_file = pwdata[EXEC_DEST_BIT];
    assign imm = pwdata[EXEC_IMM_LSB +: 8];
    assign file_rd = file_reg[fidx];
    assign spec_rd = (sidx <= SPEC_LAST) ? spec_reg[sidx] : DATA_RST;
    assign alu_minuend = (op == OP_SUB_IMM) ? imm : file_rd;

    mise_alu u_alu (
        .minuend(alu_minuend),
        .accumulator(accumulator),
        .diff(alu_diff),
        .carry(alu_c),
        .digit_carry_flag(alu_digit),
        .zero(alu_z),
        .swapped(alu_swap)
    );

    // one wait state: answer on the second access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            if (psel && penable && !pready) begin
                pslverr <= access_err(paddr, pwrite, pwdata);
                prdata <= pwrite ? 32'h0000_0000 : reg_read(paddr);
            end else begin
                pslverr <= 1'b0;
                prdata <= 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accumulator <= ACCUM_RST;
        end else if (exec_fire) begin
            unique case (op)
                OP_MOVE_SP: accumulator <= spec_rd;
                OP_SUB_REG: if (!dest_file) accumulator <= alu_diff;
                OP_SWAP: if (!dest_file) accumulator <= alu_swap;
                OP_SUB_IMM: accumulator <= alu_diff;
                default: accumulator <= accumulator;
            endcase
        end else if (wr_done && (paddr == OFF_ACCUM)) begin
            accumulator <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 128; i++) begin
                file_reg[i] <= DATA_RST;
            end
        end else if (exec_fire && dest_file && ((op == OP_SUB_REG) || (op == OP_SWAP))) begin
            file_reg[fidx] <= (op == OP_SWAP) ? alu_swap : alu_diff;
        end else if (wr_done && in_file(paddr)) begin
            file_reg[paddr[8:2]] <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 22; i++) begin
                spec_reg[i] <= DATA_RST;
            end
        end else if (exec_fire && (op == OP_LOAD_SP)) begin
            spec_reg[sidx] <= accumulator;
        end else if (wr_done && in_spec(paddr)) begin
            spec_reg[paddr[6:2]] <= pwdata[7:0];
        end
    end

    // only the two subtracts and a status register write touch the arithmetic flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_flag <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero_flag <= 1'b0;
        end else if (exec_fire && ((op == OP_SUB_REG) || (op == OP_SUB_IMM))) begin
            carry_flag <= alu_c;
            digit_carry_flag <= alu_digit;
            zero_flag <= alu_z;
        end else if (wr_done && (paddr == OFF_STATUS)) begin
            carry_flag <= pwdata[STAT_C];
            digit_carry_flag <= pwdata[STAT_DIGIT];
            zero_flag <= pwdata[STAT_Z];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timeout_flag_n <= TMOUT_RST;
            powerdown_flag_n <= PWRDN_RST;
        end else if (exec_fire && (op == OP_HALT)) begin
            timeout_flag_n <= 1'b1;
            powerdown_flag_n <= 1'b0;
        end else if (wr_done && (paddr == OFF_STATUS)) begin
            timeout_flag_n <= pwdata[STAT_TMOUT];
            powerdown_flag_n <= pwdata[STAT_PWRDN];
        end
    end

    // halt stops execution; a status write with the halt bit low wakes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_state <= ST_RUN;
        end else begin
            unique case (core_state)
                ST_RUN: if (exec_fire && (op == OP_HALT)) core_state <= ST_HALTED;
                ST_HALTED: begin
                    if (wr_done && (paddr == OFF_STATUS) && !pwdata[STAT_HALT]) begin
                        core_state <= ST_RUN;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_count <= WDT_RST;
            watchdog_prescaler <= WDT_RST;
        end else if (exec_fire && (op == OP_HALT)) begin
            watchdog_count <= WDT_RST;
            watchdog_prescaler <= WDT_RST;
        end else begin
            watchdog_prescaler <= watchdog_prescaler + 8'h01;
            if (watchdog_prescaler == PRE_WRAP) begin
                watchdog_count <= watchdog_count + 8'h01;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer0_mode_register <= TMODE_RST;
        end else if (exec_fire && (op == OP_LOAD_TMODE)) begin
            timer0_mode_register <= accumulator;
        end else if (wr_done && (paddr == OFF_TMODE)) begin
            timer0_mode_register <= pwdata[7:0];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence halt_req;
        exec_fire && (op == OP_HALT);
    endsequence

    sequence halted_exec_write;
        (core_state == ST_HALTED) && xfer_done && pwrite && (paddr == OFF_EXEC);
    endsequence

    move_special_a: assert property (
        exec_fire && (op == OP_MOVE_SP)
        |=> (accumulator == $past(spec_rd)) && $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("special page read did not reach accumulator");

    sub_reg_flags_a: assert property (
        exec_fire && (op == OP_SUB_REG)
        |=> (zero_flag == ($past(file_rd) == $past(accumulator)))
            && (digit_carry_flag == ($past(file_rd[3:0]) >= $past(accumulator[3:0]))))
        else $error("register subtract flags wrong");

    sub_dest_acc_a: assert property (
        exec_fire && (op == OP_SUB_REG) && !dest_file
        |=> accumulator == 8'($past(file_rd) - $past(accumulator)))
        else $error("register subtract result not in accumulator");

    swap_dest_file_a: assert property (
        exec_fire && (op == OP_SWAP) && dest_file
        |=> (file_reg[$past(fidx)] == {$past(file_rd[3:0]), $past(file_rd[7:4])})
            && $stable(accumulator))
        else $error("swap result not written back to file register");

    sub_imm_a: assert property (
        exec_fire && (op == OP_SUB_IMM)
        |=> accumulator == 8'($past(imm) - $past(accumulator)))
        else $error("immediate subtract result wrong");

    halt_wdt_clear_a: assert property (
        halt_req |=> (watchdog_count == 8'h00) && (watchdog_prescaler == 8'h00)
            ##1 (watchdog_prescaler == 8'h01))
        else $error("halt did not clear watchdog");

    halt_status_a: assert property (
        halt_req |=> timeout_flag_n && !powerdown_flag_n && (core_state == ST_HALTED)
            ##1 (core_state == ST_HALTED))
        else $error("halt flags or state wrong");

    halt_stops_a: assert property (
        halted_exec_write |=> $stable(accumulator) && $stable(timer0_mode_register) && pready == 1'b0)
        else $error("instruction executed while halted");

    swap_flags_a: assert property (
        exec_fire && (op == OP_SWAP) && !dest_file
        |=> (accumulator == {$past(file_rd[3:0]), $past(file_rd[7:4])})
            && $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("swap wrong or flags changed");

    tmode_load_a: assert property (
        exec_fire && (op == OP_LOAD_TMODE)
        |=> (timer0_mode_register == $past(accumulator))
            && $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("timer0 mode load wrong");

    borrow_carry_a: assert property (
        exec_fire && ((op == OP_SUB_REG) || (op == OP_SUB_IMM))
        |=> carry_flag == ($past(alu_minuend) >= $past(accumulator)))
        else $error("carry is not the inverted borrow");

    store_special_a: assert property (
        exec_fire && (op == OP_LOAD_SP)
        |=> (spec_reg[$past(sidx)] == $past(accumulator))
            && $stable({carry_flag, digit_carry_flag, zero_flag}))
        else $error("accumulator not stored to special page");
endmodule : mise_exec
`default_nettype wire

// file: mise_pkg.sv
// constants and types for the instruction subset execution block
package mise_pkg;
    // register byte offsets on the apb slave
    localparam logic [11:0] OFF_EXEC = 12'h000;
    localparam logic [11:0] OFF_ACCUM = 12'h004;
    localparam logic [11:0] OFF_STATUS = 12'h008;
    localparam logic [11:0] OFF_TMODE = 12'h00c;
    localparam logic [11:0] OFF_WDT = 12'h010;
    localparam logic [2:0] FILE_PAGE = 3'h1;
    localparam logic [4:0] SPEC_PAGE = 5'h08;
    localparam logic [4:0] SPEC_LAST = 5'h15;
    // instruction word fields
    localparam int unsigned EXEC_OP_LSB = 0;
    localparam int unsigned EXEC_OP_W = 4;
    localparam int unsigned EXEC_OPND_LSB = 8;
    localparam int unsigned EXEC_DEST_BIT = 15;
    localparam int unsigned EXEC_IMM_LSB = 16;
    // status register bits
    localparam int unsigned STAT_C = 0;
    localparam int unsigned STAT_DIGIT = 1;
    localparam int unsigned STAT_Z = 2;
    localparam int unsigned STAT_PWRDN = 3;
    localparam int unsigned STAT_TMOUT = 4;
    localparam int unsigned STAT_HALT = 5;
    // watchdog register fields
    localparam int unsigned WDT_CNT_LSB = 0;
    localparam int unsigned WDT_PRE_LSB = 8;
    // reset values
    localparam logic [7:0] ACCUM_RST = 8'h00;
    localparam logic [7:0] TMODE_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic TMOUT_RST = 1'b1;
    localparam logic PWRDN_RST = 1'b1;
    localparam logic [7:0] WDT_RST = 8'h00;
    localparam logic [7:0] PRE_WRAP = 8'hff;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_MOVE_SP = 4'h1,
        OP_LOAD_SP = 4'h2,
        OP_SUB_REG = 4'h3,
        OP_SUB_IMM = 4'h4,
        OP_HALT = 4'h5,
        OP_SWAP = 4'h6,
        OP_LOAD_TMODE = 4'h7
    } mise_op_e;

    typedef enum logic {
        ST_RUN = 1'b0,
        ST_HALTED = 1'b1
    } mise_state_e;
endpackage : mise_pkg

// file: mise_alu.sv
// subtract and nibble swap datapath
`timescale 1ns/1ps
`default_nettype none
module mise_alu (
    input wire logic [7:0] minuend,
    input wire logic [7:0] accumulator,
    output logic [7:0] diff,
    output logic carry,
    output logic digit_carry_flag,
    output logic zero,
    output logic [7:0] swapped
);
    logic [8:0] full_sum;
    logic [4:0] low_sum;

    // minuend plus inverted accumulator plus one, carry out is the inverted borrow
    assign full_sum = {1'b0, minuend} + {1'b0, ~accumulator} + 9'h001;
    assign low_sum = {1'b0, minuend[3:0]} + {1'b0, ~accumulator[3:0]} + 5'h01;
    assign diff = full_sum[7:0];
    assign carry = full_sum[8];
    assign digit_carry_flag = low_sum[4];
    assign zero = (full_sum[7:0] == 8'h00);
    assign swapped = {minuend[3:0], minuend[7:4]};
endmodule : mise_alu
`default_nettype wire

// file: mcu_instruction_subset_exec_tb_top.sv
// self-checking testbench for the instruction subset execution block
`timescale 1ns/1ps
`default_nettype none
module mcu_instruction_subset_exec_tb_top;
    import mise_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] tmode;
    mise_state_e core_state;
    int errors = 0;
    int comparisons = 0;
    // subtract cases: opcode, minuend, accumulator, destination, file index
    logic [3:0] s_op [6] = '{4'h3, 4'h3, 4'h3, 4'h4, 4'h4, 4'h4};
    logic [7:0] s_m [6] = '{8'h05, 8'h06, 8'h06, 8'h05, 8'h10, 8'hff};
    logic [7:0] s_a [6] = '{8'h06, 8'h05, 8'h06, 8'h06, 8'h01, 8'hff};
    logic s_d [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic [6:0] s_r [6] = '{7'd127, 7'd127, 7'd0, 7'd0, 7'd0, 7'd0};

    always #5 pclk = ~pclk;

    mise_exec dut_u (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .timer0_mode_register(tmode), .core_state(core_state)
    );

    task automatic close_out();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("Error apb answer expected 1 seen %b", pready);
            close_out();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
        check("write error", {31'h0, exp_err}, {31'h0, err});
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string name);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        check("read error", 32'h0, {31'h0, err});
        check(name, exp, rd);
    endtask : rd_chk

    task automatic exec(input logic [3:0] op, input logic [6:0] opnd, input logic d,
                        input logic [7:0] imm, input logic exp_err);
        wr(OFF_EXEC, {8'h00, imm, d, opnd, 4'h0, op}, exp_err);
    endtask : exec

    function automatic logic [11:0] fa(input logic [6:0] i);
        return 12'h200 + {3'h0, i, 2'b00};
    endfunction : fa

    function automatic logic [11:0] sa(input logic [4:0] i);
        return 12'h400 + {5'h00, i, 2'b00};
    endfunction : sa

    initial begin
        logic [7:0] res;
        logic [2:0] fl;
        logic [31:0] v;
        logic e;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        check("timer0 mode port reset", 32'h0, {24'h0, tmode});
        rd_chk(OFF_ACCUM, 32'h0, "accumulator reset");
        rd_chk(OFF_STATUS, 32'h18, "status reset");
        rd_chk(OFF_TMODE, 32'h0, "timer0 mode reset");
        // subtracts with flag and destination checks
        for (int k = 0; k < 6; k++) begin
            res = s_m[k] - s_a[k];
            fl = {res == 8'h00, s_m[k][3:0] >= s_a[k][3:0], s_m[k] >= s_a[k]};
            wr(OFF_STATUS, 32'h18, 1'b0);
            wr(OFF_ACCUM, {24'h0, s_a[k]}, 1'b0);
            if (s_op[k] == OP_SUB_REG) begin
                wr(fa(s_r[k]), {24'h0, s_m[k]}, 1'b0);
            end
            exec(s_op[k], s_r[k], s_d[k], s_m[k], 1'b0);
            rd_chk(OFF_STATUS, {27'h0, 2'b11, fl}, "status flags");
            rd_chk(OFF_ACCUM, {24'h0, s_d[k] ? s_a[k] : res}, "accumulator");
            if (s_op[k] == OP_SUB_REG) begin
                rd_chk(fa(s_r[k]), {24'h0, s_d[k] ? res : s_m[k]}, "file reg");
            end
        end
        // nibble swap both destinations
        wr(fa(7'd5), 32'ha5, 1'b0);
        wr(OFF_STATUS, 32'h1f, 1'b0);
        exec(OP_SWAP, 7'd5, 1'b1, 8'h00, 1'b0);
        rd_chk(fa(7'd5), 32'h5a, "swapped file");
        exec(OP_SWAP, 7'd5, 1'b0, 8'h00, 1'b0);
        rd_chk(OFF_ACCUM, 32'ha5, "swapped accumulator");
        rd_chk(fa(7'd5), 32'h5a, "file kept");
        rd_chk(OFF_STATUS, 32'h1f, "flags after swap");
        // special page move and store, top index and one beyond
        wr(sa(5'd21), 32'h3c, 1'b0);
        exec(OP_MOVE_SP, 7'd21, 1'b0, 8'h00, 1'b0);
        rd_chk(OFF_ACCUM, 32'h3c, "moved special");
        exec(OP_MOVE_SP, 7'd22, 1'b0, 8'h00, 1'b1);
        wr(OFF_ACCUM, 32'hc3, 1'b0);
        exec(OP_LOAD_SP, 7'd0, 1'b0, 8'h00, 1'b0);
        rd_chk(sa(5'd0), 32'hc3, "stored special");
        exec(OP_LOAD_TMODE, 7'd0, 1'b0, 8'h00, 1'b0);
        @(negedge pclk);
        check("timer0 mode port", 32'hc3, {24'h0, tmode});
        rd_chk(OFF_TMODE, 32'hc3, "timer0 mode");
        rd_chk(OFF_STATUS, 32'h1f, "flags kept");
        // refusals
        exec(4'h8, 7'd0, 1'b0, 8'h00, 1'b1);
        wr(OFF_WDT, 32'h0, 1'b1);
        apb(1'b0, 12'h014, 32'h0, v, e);
        check("unmapped error", 32'h1, {31'h0, e});
        // halt after the watchdog has advanced
        wr(OFF_STATUS, 32'h08, 1'b0);
        repeat (300) @(posedge pclk);
        apb(1'b0, OFF_WDT, 32'h0, v, e);
        check("watchdog running", 32'h1, {31'h0, v[7:0] != 8'h00});
        exec(OP_HALT, 7'd0, 1'b0, 8'h00, 1'b0);
        apb(1'b0, OFF_WDT, 32'h0, v, e);
        check("watchdog cleared", 32'h1, {31'h0, v[7:0] == 8'h00 && v[15:8] < 8'h10});
        rd_chk(OFF_STATUS, 32'h30, "status after halt");
        check("core halted", {31'h0, ST_HALTED}, {31'h0, core_state});
        exec(OP_NOP, 7'd0, 1'b0, 8'h00, 1'b1);
        wr(OFF_STATUS, 32'h00, 1'b0);
        @(negedge pclk);
        check("core woken", {31'h0, ST_RUN}, {31'h0, core_state});
        close_out();
    end
endmodule : mcu_instruction_subset_exec_tb_top
`default_nettype wire
